// ==== core/chan_prot_defs.svh ====
`ifndef CHAN_PROT_DEFS_SVH
`define CHAN_PROT_DEFS_SVH
`define CHAN_COUNT      10
`define CLK_MHZ         50
`define FAST_TRIP_US    21
`define SLOW_TRIP_US    40
`define REARM_US        24
`define FAST_TRIP_CYC   (`FAST_TRIP_US * `CLK_MHZ)
`define SLOW_TRIP_CYC   (`SLOW_TRIP_US * `CLK_MHZ)
`define REARM_CYC       (`REARM_US * `CLK_MHZ)
`define CNT_W           12
`define DIAG_NONE       2'h0
`define DIAG_FAULT      2'h2
`endif

// ==== core/chan_prot_pkg.sv ====
`include "chan_prot_defs.svh"
package chan_prot_pkg;
  typedef logic [`CHAN_COUNT-1:0] chan_vec_t;
  // analogue comparator results, one bit per channel
  typedef struct packed {
    chan_vec_t highTrip;   // above high trip level
    chan_vec_t lowTrip;    // above low trip level
    chan_vec_t overTemp;   // thermal shutdown
    chan_vec_t revDetect;  // reverse current present
    chan_vec_t revRelease; // reverse current beyond release level
  } comp_in_t;
  typedef enum logic [1:0] {GUARD_IDLE, GUARD_ON, GUARD_BLOCKED, GUARD_REARM} guard_state_t;
endpackage : chan_prot_pkg

// ==== core/low_side_channel_protection.sv ====
`include "chan_prot_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module low_side_channel_protection #(
  parameter int FAST_TRIP_CYCLES = `FAST_TRIP_CYC, // fast trip delay in clocks
  parameter int SLOW_TRIP_CYCLES = `SLOW_TRIP_CYC, // slow trip delay in clocks
  parameter int REARM_CYCLES     = `REARM_CYC      // guard rearm delay in clocks
) (
  input  wire logic                     clk,            // 50 MHz clock
  input  wire logic                     rst,            // async reset, high
  input  wire chan_prot_pkg::chan_vec_t parCtrlIn,      // parallel control pins
  input  wire chan_prot_pkg::comp_in_t  compIn,         // comparator pins
  input  wire logic                     guardEnable,    // reverse guard enable bit
  input  wire logic                     diagWriteBusy,  // diagnosis write in progress
  input  wire chan_prot_pkg::chan_vec_t diagBankClear,  // clear pulse per channel
  output var  chan_prot_pkg::chan_vec_t chanOutput,     // output stage on
  output var  chan_prot_pkg::chan_vec_t faultLatched,   // channel latched off
  output var  chan_prot_pkg::chan_vec_t diagCommit,     // fault committed pulse
  output var  logic [2*`CHAN_COUNT-1:0] diagEntry       // diagnosis code per channel
);
  import chan_prot_pkg::*;

  localparam int N = `CHAN_COUNT;
  // terminal counts cut to the counter width on purpose; defaults fit well below it
  localparam logic [`CNT_W-1:0] FAST_CYC  = `CNT_W'(FAST_TRIP_CYCLES);
  localparam logic [`CNT_W-1:0] SLOW_CYC  = `CNT_W'(SLOW_TRIP_CYCLES);
  localparam logic [`CNT_W-1:0] REARM_CYC = `CNT_W'(REARM_CYCLES);

  // ------------------------------------------------------------
  // input synchronisers, three stages, change on stage agreement
  // ------------------------------------------------------------
  logic [N*6-1:0] syncA_reg;
  logic [N*6-1:0] syncB_reg;
  logic [N*6-1:0] syncC_reg;
  logic [N*6-1:0] syncOut_reg;
  logic [N*6-1:0] rawPins;
  assign rawPins = {parCtrlIn, compIn};

  // three-flop chain per pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      syncC_reg <= '0;
    end else begin
      syncA_reg <= rawPins;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  // accept a change once stages two and three agree
  // a single-cycle glitch on a pin never reaches the channel logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncOut_reg <= '0;
    end else begin
      for (int i = 0; i < N*6; i++) begin
        if (syncB_reg[i] == syncC_reg[i]) begin
          syncOut_reg[i] <= syncC_reg[i];
        end
      end
    end
  end

  chan_vec_t inSync;
  comp_in_t  cmp;
  assign inSync = syncOut_reg[N*6-1 -: N];
  assign cmp    = comp_in_t'(syncOut_reg[N*5-1:0]);

  // faults held back while a diagnosis write runs
  chan_vec_t faultHold_reg;

  // ------------------------------------------------------------
  // per-channel protection
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_chan
      logic [`CNT_W-1:0] fastCnt_reg;
      logic [`CNT_W-1:0] slowCnt_reg;
      logic [`CNT_W-1:0] rearmCnt_reg;
      guard_state_t      guard_reg;
      logic              trip;
      logic              latch_reg;

      // ----------------------------------------
      // overload trip counters
      // ----------------------------------------
      // fast trip counter, restarts when high comparator drops
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fastCnt_reg <= '0;
        end else if (!cmp.highTrip[g] || latch_reg) begin
          fastCnt_reg <= '0;
        end else if (fastCnt_reg != FAST_CYC) begin
          fastCnt_reg <= fastCnt_reg + `CNT_W'(1);
        end
      end

      // slow trip counter on the low comparator
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          slowCnt_reg <= '0;
        end else if (!cmp.lowTrip[g] || latch_reg) begin
          slowCnt_reg <= '0;
        end else if (slowCnt_reg != SLOW_CYC) begin
          slowCnt_reg <= slowCnt_reg + `CNT_W'(1);
        end
      end

      // both trips and thermal shutdown feed one fault
      assign trip = (fastCnt_reg == FAST_CYC) || (slowCnt_reg == SLOW_CYC)
                    || cmp.overTemp[g];

      // ----------------------------------------
      // fault latch
      // ----------------------------------------
      // latch off until diagnosis clear; trip wins over clear
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          latch_reg <= 1'b0;
        end else if (trip) begin
          latch_reg <= 1'b1;
        end else if (diagBankClear[g]) begin
          latch_reg <= 1'b0;
        end
      end

      // ----------------------------------------
      // diagnosis commit
      // ----------------------------------------
      // hold a fault while a diagnosis write runs, commit after
      // the pending flag outlasts any write length, so no trip is dropped
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          faultHold_reg[g] <= 1'b0;
          diagCommit[g]    <= 1'b0;
          diagEntry[2*g+:2] <= `DIAG_NONE;
        end else begin
          diagCommit[g] <= 1'b0;
          if (diagWriteBusy) begin
            if (trip) begin
              faultHold_reg[g] <= 1'b1;
            end
          end else if (trip || faultHold_reg[g]) begin
            faultHold_reg[g]  <= 1'b0;
            diagCommit[g]     <= 1'b1;
            diagEntry[2*g+:2] <= `DIAG_FAULT;
          end else if (diagBankClear[g]) begin
            diagEntry[2*g+:2] <= `DIAG_NONE;
          end
        end
      end

      // ----------------------------------------
      // reverse-current guard
      // ----------------------------------------
      // reverse-current guard sequencing
      // the rearm count runs only while both comparators stay quiet
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          guard_reg    <= GUARD_IDLE;
          rearmCnt_reg <= '0;
        end else if (!guardEnable) begin
          guard_reg    <= GUARD_IDLE;
          rearmCnt_reg <= '0;
        end else begin
          case (guard_reg)
            GUARD_IDLE: begin
              if (cmp.revDetect[g]) begin
                guard_reg <= GUARD_ON;
              end
            end
            GUARD_ON: begin
              if (cmp.revRelease[g]) begin
                guard_reg <= GUARD_BLOCKED;
              end else if (!cmp.revDetect[g]) begin
                guard_reg <= GUARD_IDLE;
              end
            end
            GUARD_BLOCKED: begin
              rearmCnt_reg <= '0;
              if (!cmp.revDetect[g] && !cmp.revRelease[g]) begin
                guard_reg <= GUARD_REARM;
              end
            end
            GUARD_REARM: begin
              if (cmp.revDetect[g] || cmp.revRelease[g]) begin
                guard_reg    <= GUARD_BLOCKED;
              end else if (rearmCnt_reg == REARM_CYC - `CNT_W'(1)) begin
                guard_reg    <= GUARD_IDLE;
              end else begin
                rearmCnt_reg <= rearmCnt_reg + `CNT_W'(1);
              end
            end
            default: begin
              guard_reg <= GUARD_IDLE;
            end
          endcase
        end
      end

      // ----------------------------------------
      // output stage
      // ----------------------------------------
      // output stage drive
      // guard on overrides the latch so reverse current avoids the body diode
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          chanOutput[g]   <= 1'b0;
          faultLatched[g] <= 1'b0;
        end else begin
          faultLatched[g] <= latch_reg;
          chanOutput[g]   <= (inSync[g] && !latch_reg && !trip)
                             || (guard_reg == GUARD_ON);
        end
      end
    end
  endgenerate
endmodule : low_side_channel_protection
`default_nettype wire

// ==== tb/host_par_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_par_model (
  input  wire logic                     clk,           // device clock
  input  wire chan_prot_pkg::chan_vec_t wantOn,        // channels wanted on
  input  wire chan_prot_pkg::chan_vec_t relChan,       // channels to release
  output var  chan_prot_pkg::chan_vec_t parCtrlIn,     // parallel pins
  output var  chan_prot_pkg::chan_vec_t diagBankClear  // clear commands
);
  import chan_prot_pkg::*;
  // a released channel stays low while its bank clears, then may go on
  // the first falling edge settles the pins while reset still holds
  always @(negedge clk) begin
    parCtrlIn <= wantOn & ~relChan;
    diagBankClear <= relChan;
  end
endmodule : host_par_model
`default_nettype wire

// ==== tb/low_side_channel_protection_sva.sv ====
`include "chan_prot_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module low_side_channel_protection_sva (
  input wire logic                     clk,           // clock
  input wire logic                     rst,           // reset
  input wire chan_prot_pkg::chan_vec_t parCtrlIn,     // pins
  input wire chan_prot_pkg::comp_in_t  compIn,        // comparators
  input wire logic                     guardEnable,   // guard enable
  input wire logic                     diagWriteBusy, // write busy
  input wire chan_prot_pkg::chan_vec_t diagBankClear, // clears
  input wire chan_prot_pkg::chan_vec_t chanOutput,    // outputs
  input wire chan_prot_pkg::chan_vec_t faultLatched,  // latches
  input wire chan_prot_pkg::chan_vec_t diagCommit,    // commits
  input wire logic [2*`CHAN_COUNT-1:0] diagEntry      // codes
);
  import chan_prot_pkg::*;
  localparam int FAST = `FAST_TRIP_CYC + 10;
  localparam int SLOW = `SLOW_TRIP_CYC + 10;
  logic [11:0] hiCnt;
  logic [11:0] loCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent above the high level on channel 5
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hiCnt <= '0;
    else hiCnt <= compIn.highTrip[5] ? hiCnt + 12'h001 : 12'h000;
  end
  // cycles spent above the low level on channel 7
  always_ff @(posedge clk or posedge rst) begin
    if (rst) loCnt <= '0;
    else loCnt <= compIn.lowTrip[7] ? loCnt + 12'h001 : 12'h000;
  end
  sequence s_idle; (!guardEnable && parCtrlIn == '0) [*6]; endsequence
  sequence s_latched; faultLatched[3] ##1 faultLatched[3]; endsequence
  property p_idle_off; s_idle |-> chanOutput == '0; endproperty
  property p_busy_hold; diagWriteBusy [*3] |-> diagCommit == '0; endproperty
  property p_commit_code; diagCommit[1] |-> diagEntry[3:2] == `DIAG_FAULT; endproperty
  property p_latched_off; s_latched |-> !$past(chanOutput[3]); endproperty
  property p_latch_kept; faultLatched[3] && !diagBankClear[3] && !$past(diagBankClear[3]) |=> faultLatched[3]; endproperty
  property p_temp_trip; compIn.overTemp[3] [*8] |-> faultLatched[3]; endproperty
  property p_fast_trip; hiCnt == FAST |-> faultLatched[5]; endproperty
  property p_slow_trip; loCnt == SLOW |-> faultLatched[7]; endproperty
  a_idle_off:
    assert property (p_idle_off) else $error("output on while idle");
  a_busy_hold:
    assert property (p_busy_hold) else $error("commit during write");
  a_commit_code:
    assert property (p_commit_code) else $error("wrong committed code");
  a_latched_off:
    assert property (p_latched_off) else $error("latched channel on");
  a_latch_kept:
    assert property (p_latch_kept) else $error("latch lost without clear");
  a_temp_trip:
    assert property (p_temp_trip) else $error("no thermal trip");
  a_fast_trip:
    assert property (p_fast_trip) else $error("fast trip late");
  a_slow_trip:
    assert property (p_slow_trip) else $error("slow trip late");
endmodule : low_side_channel_protection_sva
bind low_side_channel_protection low_side_channel_protection_sva chk (.clk(clk), .rst(rst), .parCtrlIn(parCtrlIn),
  .compIn(compIn), .guardEnable(guardEnable), .diagWriteBusy(diagWriteBusy), .diagBankClear(diagBankClear),
  .chanOutput(chanOutput), .faultLatched(faultLatched), .diagCommit(diagCommit), .diagEntry(diagEntry));
`default_nettype wire

// ==== tb/test_low_side_channel_protection.sv ====
`include "chan_prot_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_low_side_channel_protection;
  import chan_prot_pkg::*;
  logic clk, rst, guardEnable, diagWriteBusy;
  comp_in_t comp;
  chan_vec_t wantOn, relChan, parCtrlIn, diagBankClear, chanOutput, faultLatched, diagCommit;
  logic [2*`CHAN_COUNT-1:0] diagEntry;
  int fails, check_count, cyc;
  host_par_model host (.clk(clk), .wantOn(wantOn), .relChan(relChan), .parCtrlIn(parCtrlIn),
    .diagBankClear(diagBankClear));
  low_side_channel_protection dut (.clk(clk), .rst(rst), .parCtrlIn(parCtrlIn), .compIn(comp),
    .guardEnable(guardEnable), .diagWriteBusy(diagWriteBusy), .diagBankClear(diagBankClear),
    .chanOutput(chanOutput), .faultLatched(faultLatched), .diagCommit(diagCommit), .diagEntry(diagEntry));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task cmp(string n, chan_vec_t e, chan_vec_t g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task w(int n);
    repeat (n) @(negedge clk);
  endtask : w
  task rel(chan_vec_t c);
    relChan = c;
    w(4);
    relChan = '0;
    w(8);
    cmp("faultLatched", 10'h000, faultLatched);
  endtask : rel
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_inputs;
    for (int i = 0; i < `CHAN_COUNT; i++) begin
      wantOn = chan_vec_t'(1 << i);
      w(8);
      cmp("chanOutput", wantOn, chanOutput);
    end
    wantOn = '0;
    w(8);
    cmp("chanOutput", 10'h000, chanOutput);
    $display("t_inputs done");
  endtask : t_inputs
  task t_temp;
    wantOn = '1;
    comp.overTemp[3] = 1'h1;
    w(8);
    comp.overTemp[3] = 1'h0;
    cmp("faultLatched", 10'h008, faultLatched);
    cmp("diagEntry", 10'h080, diagEntry[9:0]);
    w(8);
    cmp("chanOutput", 10'h3f7, chanOutput);
    rel(10'h008);
    cmp("chanOutput", 10'h3ff, chanOutput);
    cmp("diagEntry", 10'h000, diagEntry[9:0]);
    $display("t_temp done");
  endtask : t_temp
  task t_fast;
    comp.highTrip[5] = 1'h1;
    w(1000);
    comp.highTrip[5] = 1'h0;
    w(10);
    comp.highTrip[5] = 1'h1;
    w(`FAST_TRIP_CYC - 1);
    cmp("faultLatched", 10'h000, faultLatched);
    w(12);
    comp.highTrip[5] = 1'h0;
    cmp("faultLatched", 10'h020, faultLatched);
    cmp("chanOutput", 10'h3df, chanOutput);
    cmp("diagEntry", 10'h002, diagEntry[19:10]);
    rel(10'h020);
    $display("t_fast done");
  endtask : t_fast
  task t_slow;
    comp.lowTrip[7] = 1'h1;
    w(`SLOW_TRIP_CYC - 1);
    cmp("faultLatched", 10'h000, faultLatched);
    w(12);
    comp.lowTrip[7] = 1'h0;
    cmp("faultLatched", 10'h080, faultLatched);
    cmp("chanOutput", 10'h37f, chanOutput);
    cmp("diagEntry", 10'h020, diagEntry[19:10]);
    rel(10'h080);
    $display("t_slow done");
  endtask : t_slow
  task t_busy;
    diagWriteBusy = 1'h1;
    comp.overTemp[1] = 1'h1;
    w(8);
    comp.overTemp[1] = 1'h0;
    w(4);
    cmp("diagEntry", 10'h000, diagEntry[9:0]);
    diagWriteBusy = 1'h0;
    repeat (4) if (diagCommit !== 10'h002) w(1);
    cmp("diagCommit", 10'h002, diagCommit);
    w(1);
    cmp("diagEntry", 10'h008, diagEntry[9:0]);
    rel(10'h002);
    $display("t_busy done");
  endtask : t_busy
  task t_guard;
    wantOn = '0;
    comp.revDetect[2] = 1'h1;
    w(8);
    cmp("chanOutput", 10'h000, chanOutput);
    guardEnable = 1'h1;
    w(8);
    cmp("chanOutput", 10'h004, chanOutput);
    comp.revRelease[2] = 1'h1;
    w(8);
    cmp("chanOutput", 10'h000, chanOutput);
    comp.revRelease[2] = 1'h0;
    w(8);
    cmp("chanOutput", 10'h000, chanOutput);
    comp.revDetect[2] = 1'h0;
    w(`REARM_CYC - 100);
    comp.revDetect[2] = 1'h1;
    w(8);
    cmp("chanOutput", 10'h000, chanOutput);
    comp.revDetect[2] = 1'h0;
    w(`REARM_CYC + 20);
    comp.revDetect[2] = 1'h1;
    w(8);
    cmp("chanOutput", 10'h004, chanOutput);
    comp.revDetect[2] = 1'h0;
    guardEnable = 1'h0;
    $display("t_guard done");
  endtask : t_guard
  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    rst = 1'h1;
    guardEnable = 1'h0;
    diagWriteBusy = 1'h0;
    comp = '0;
    wantOn = '0;
    relChan = '0;
    w(6);
    rst = 1'h0;
    w(2);
    t_inputs();
    t_temp();
    t_fast();
    t_slow();
    t_busy();
    t_guard();
    summarize();
  end
endmodule : test_low_side_channel_protection
`default_nettype wire
